// file: pkg/flash_ctrl_pkg.sv
// Constants and carrier types for the flash driver control register block.
// Assumes a register port already decoded from the serial host interface.
package flash_ctrl_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h04;
  localparam logic [7:0] FAULT_OFFSET = 8'h05;
  localparam int MODE_LSB = 0;
  localparam int STROBE_EN_BIT = 2;
  localparam int OUT_EN_BIT = 3;
  localparam int LAMP_PIN_EN_BIT = 4;
  localparam int STROBE_LEVEL_BIT = 5;
  localparam int LIMIT_LSB = 6;
  localparam int FAULT_COIL_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'hB4;
  // Fixed currents for parallel interface mode, in mA.
  localparam logic [9:0] PAR_LAMP_SINGLE_MA = 10'h050;
  localparam logic [9:0] PAR_LAMP_DUAL_MA = 10'h028;
  localparam logic [9:0] PAR_FLASH_SINGLE_MA = 10'h1F4;
  localparam logic [9:0] PAR_FLASH_DUAL_MA = 10'h140;
  // Inductor peak limit in mA per code.
  localparam logic [11:0] LIMIT_00_MA = 12'h4E2;
  localparam logic [11:0] LIMIT_01_MA = 12'h5DC;
  localparam logic [11:0] LIMIT_10_MA = 12'h6D6;
  localparam logic [11:0] LIMIT_11_MA = 12'h7D0;

  typedef enum logic [1:0] {
    MODE_LAMP_PIN = 2'h0,
    MODE_INDICATOR = 2'h1,
    MODE_ASSIST = 2'h2,
    MODE_FLASH = 2'h3
  } op_mode_t;

  typedef struct packed {
    logic [1:0] inductor_peak_limit;
    logic strobeLevel;
    logic lampPinEn;
    logic outEn;
    logic strobeEn;
    op_mode_t mode;
  } ctrl_reg_t;

  typedef struct packed {
    logic lampOn;
    logic indicatorOn;
    logic assistOn;
    logic flashOn;
  } drive_t;
endpackage : flash_ctrl_pkg

// file: rtl/flash_driver_control_register.sv
// Control register of a flash LED driver with mode, trigger and current decoding.
// Assumes a decoded register port (one-cycle write/read strobes) and sys_clk pins.
//
// Function
// - Mode bits 1:0 choose lamp-pin, indicator, assist or flash, serial mode only.
// - Bit 2 enables trigger input; trigger acts only in flash mode.
// - Bit 3 enables current sources; hardware clears it after a flash pulse.
// - Bit 4 lets lamp-request pin request lamp operation with mode 00.
// - Bit 5 selects trigger sensing: 0 edge, 1 level.
// - Bits 7:6 select inductor peak limit 1.25A to 2.0A, default 10.
// - Parallel mode uses fixed lamp/assist current 80mA single, 40mA dual.
// - Parallel mode uses fixed flash current 500mA single, 320mA each dual.
// - Fault flag sets when inductor current exceeds selected limit.
`timescale 1ns/1ns
`default_nettype none
module flash_driver_control_register #(
  parameter int TIMEOUT_CYCLES = 20000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port, strobes one cycle wide.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Interface select, pins and coil current measurement.
  input wire logic parallelMode,
  input wire logic dualLed,
  input wire logic strobePin,
  input wire logic lampPin,
  input wire logic [11:0] coilCurrentMa,
  // Registered drive state and status.
  output flash_ctrl_pkg::drive_t drive,
  output logic [9:0] currentMa,
  output logic [1:0] inductor_peak_limit,
  output logic coilFault
);
  flash_ctrl_pkg::ctrl_reg_t ctrl_ff, nxt_ctrl;
  // Pin synchronisers and filtered levels.
  logic [2:0] strobeSync_ff, nxt_strobeSync;
  logic [2:0] lampSync_ff, nxt_lampSync;
  logic strobeLvl_ff, nxt_strobeLvl;
  logic lampLvl_ff, nxt_lampLvl;
  // Flash pulse state and its timeout counter.
  logic flashAct_ff, nxt_flashAct;
  logic [31:0] tmo_ff, nxt_tmo;
  // Status and read-back registers.
  logic coilFault_ff, nxt_coilFault;
  logic [7:0] rdata_ff, nxt_rdata;
  flash_ctrl_pkg::drive_t drive_ff, nxt_drive;
  logic [9:0] cur_ff, nxt_cur;

  // Combinational helpers.
  logic [11:0] limitMa;
  logic strobeRise;
  logic flashEnd;

  // The limit code selects the threshold for the coil current comparison.
  always_comb begin
    unique case (ctrl_ff.inductor_peak_limit)
      2'h0: limitMa = flash_ctrl_pkg::LIMIT_00_MA;
      2'h1: limitMa = flash_ctrl_pkg::LIMIT_01_MA;
      2'h2: limitMa = flash_ctrl_pkg::LIMIT_10_MA;
      2'h3: limitMa = flash_ctrl_pkg::LIMIT_11_MA;
    endcase
  end

  // A pin level counts only once two synchroniser stages agree, which filters glitches.
  always_comb begin
    nxt_strobeSync = {strobeSync_ff[1:0], strobePin};
    nxt_lampSync = {lampSync_ff[1:0], lampPin};
    nxt_strobeLvl = strobeLvl_ff;
    nxt_lampLvl = lampLvl_ff;
    if (strobeSync_ff[1] == strobeSync_ff[2]) begin
      nxt_strobeLvl = strobeSync_ff[2];
    end
    if (lampSync_ff[1] == lampSync_ff[2]) begin
      nxt_lampLvl = lampSync_ff[2];
    end
    strobeRise = nxt_strobeLvl & ~strobeLvl_ff;
  end

  // Flash pulse control: start conditions, end conditions and the enable auto-clear.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_flashAct = flashAct_ff;
    nxt_tmo = tmo_ff;
    flashEnd = 1'b0;
    if (regWrite && regAddr == flash_ctrl_pkg::CTRL_OFFSET) begin
      nxt_ctrl = flash_ctrl_pkg::ctrl_reg_t'(regWdata);
    end
    if (flashAct_ff) begin
      nxt_tmo = tmo_ff + 32'h1;
      if (tmo_ff >= 32'(TIMEOUT_CYCLES - 1)) begin
        flashEnd = 1'b1;
      end
      if (ctrl_ff.strobeLevel && ctrl_ff.strobeEn && !strobeLvl_ff) begin
        flashEnd = 1'b1;
      end
      // Software turning the output or mode off also ends the pulse.
      if (!ctrl_ff.outEn || ctrl_ff.mode != flash_ctrl_pkg::MODE_FLASH) begin
        flashEnd = 1'b1;
      end
    end else if (!parallelMode && ctrl_ff.outEn && ctrl_ff.mode == flash_ctrl_pkg::MODE_FLASH) begin
      if (!ctrl_ff.strobeEn) begin
        nxt_flashAct = 1'b1;
      end else if (ctrl_ff.strobeLevel ? strobeLvl_ff : strobeRise) begin
        nxt_flashAct = 1'b1;
      end
      // The counter restarts at every pulse start, so each pulse gets the full time.
      nxt_tmo = 32'h0;
    end
    if (flashEnd) begin
      nxt_flashAct = 1'b0;
      nxt_ctrl.outEn = 1'b0;
    end
  end

  // Parallel mode ignores the control register and drives fixed currents.
  always_comb begin
    nxt_drive = '0;
    nxt_cur = 10'h000;
    if (parallelMode) begin
      nxt_drive.flashOn = strobeLvl_ff;
      nxt_drive.lampOn = lampLvl_ff & ~strobeLvl_ff;
      if (strobeLvl_ff) begin
        nxt_cur = dualLed ? flash_ctrl_pkg::PAR_FLASH_DUAL_MA : flash_ctrl_pkg::PAR_FLASH_SINGLE_MA;
      end else if (lampLvl_ff) begin
        nxt_cur = dualLed ? flash_ctrl_pkg::PAR_LAMP_DUAL_MA : flash_ctrl_pkg::PAR_LAMP_SINGLE_MA;
      end
    end else if (ctrl_ff.outEn) begin
      unique case (ctrl_ff.mode)
        flash_ctrl_pkg::MODE_LAMP_PIN: begin
          nxt_drive.lampOn = ctrl_ff.lampPinEn & lampLvl_ff;
        end
        flash_ctrl_pkg::MODE_INDICATOR: nxt_drive.indicatorOn = 1'b1;
        flash_ctrl_pkg::MODE_ASSIST: nxt_drive.assistOn = 1'b1;
        flash_ctrl_pkg::MODE_FLASH: nxt_drive.flashOn = flashAct_ff;
      endcase
    end
  end

  always_comb begin
    // Reading the fault register clears the flag, but a fault in that cycle sets it again.
    // sticky coil fault
    nxt_coilFault = coilFault_ff | (coilCurrentMa > limitMa);
    nxt_rdata = 8'h00;
    if (regRead && regAddr == flash_ctrl_pkg::CTRL_OFFSET) begin
      nxt_rdata = ctrl_ff;
    end else if (regRead && regAddr == flash_ctrl_pkg::FAULT_OFFSET) begin
      nxt_rdata[flash_ctrl_pkg::FAULT_COIL_BIT] = coilFault_ff;
      nxt_coilFault = coilCurrentMa > limitMa;
    end else if (!regRead) begin
      nxt_rdata = rdata_ff;
    end
  end

  // Synchronisers and pin levels.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strobeSync_ff <= 3'h0;
      lampSync_ff <= 3'h0;
      strobeLvl_ff <= 1'b0;
      lampLvl_ff <= 1'b0;
    end else begin
      strobeSync_ff <= nxt_strobeSync;
      lampSync_ff <= nxt_lampSync;
      strobeLvl_ff <= nxt_strobeLvl;
      lampLvl_ff <= nxt_lampLvl;
    end
  end

  // Control register and flash pulse state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_ff <= flash_ctrl_pkg::ctrl_reg_t'(flash_ctrl_pkg::CTRL_RESET);
      flashAct_ff <= 1'b0;
      tmo_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      flashAct_ff <= nxt_flashAct;
      tmo_ff <= nxt_tmo;
    end
  end

  // Drive state and current.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_ff <= '0;
      cur_ff <= 10'h000;
    end else begin
      drive_ff <= nxt_drive;
      cur_ff <= nxt_cur;
    end
  end

  // Fault flag and read data.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      coilFault_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      coilFault_ff <= nxt_coilFault;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs come straight from registers.
  assign regRdata = rdata_ff;
  assign drive = drive_ff;
  assign currentMa = cur_ff;
  assign inductor_peak_limit = ctrl_ff.inductor_peak_limit;
  assign coilFault = coilFault_ff;
endmodule : flash_driver_control_register
`default_nettype wire

// file: verif/flash_host_model.sv
// Host side of the register port.
// Assumes strobes taken at the rising edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge sys_clk);
    d = regRdata;
  endtask : rd
endmodule : flash_host_model
`default_nettype wire

// file: verif/flash_ctrl_monitor.sv
// Port checker, bound from the bench top.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
module flash_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic parallelMode,
  input wire logic dualLed,
  input wire logic [11:0] coilCurrentMa,
  input wire flash_ctrl_pkg::drive_t drive,
  input wire logic [9:0] currentMa,
  input wire logic [1:0] inductor_peak_limit,
  input wire logic coilFault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_LIM: assert property (regWrite && regAddr == 8'h04
    |=> inductor_peak_limit == $past(regWdata[7:6])) else $error("limit bad");
  AST_UNMAP: assert property (regRead && regAddr > 8'h05
    |=> regRdata == 8'h00) else $error("unmapped read bad");
  AST_HOLD: assert property (!regRead |=> $stable(regRdata)) else $error("rdata moved");
  AST_FLT: assert property (inductor_peak_limit == 2'h2 && coilCurrentMa > 12'h6D6
    |-> ##[1:2] coilFault) else $error("fault missed");
  AST_ONE: assert property ($onehot0(drive)) else $error("two drives");
  AST_PF: assert property (parallelMode && $past(parallelMode) && $stable(dualLed)
    && drive.flashOn |-> currentMa == (dualLed ? 10'h140 : 10'h1F4)) else $error("pf");
  AST_PL: assert property (parallelMode && $past(parallelMode) && $stable(dualLed)
    && drive.lampOn |-> currentMa == (dualLed ? 10'h028 : 10'h050)) else $error("pl");
  AST_SER: assert property (!parallelMode && !$past(parallelMode)
    |-> currentMa == 10'h000) else $error("serial current");
  AST_CLR: assert property ($fell(drive.flashOn) ##[1:3] (regRead && regAddr == 8'h04)
    |=> !regRdata[3]) else $error("enable kept");
  COV_F: cover property ($rose(drive.flashOn));
  COV_L: cover property ($rose(drive.lampOn));
  COV_C: cover property ($rose(coilFault));
endmodule : flash_ctrl_monitor
`default_nettype wire

// file: verif/tb_top.sv
// Bench top: host model, pin stimulus, checks.
// Assumes the package and design compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t bad", $time); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite, regRead, coilFault;
  logic [7:0] regAddr, regWdata, regRdata, rv;
  logic parallelMode = 1'b0, dualLed = 1'b0, strobePin = 1'b0, lampPin = 1'b0;
  logic [11:0] coilCurrentMa = 12'h000;
  flash_ctrl_pkg::drive_t drive;
  logic [9:0] currentMa;
  logic [1:0] inductor_peak_limit;
  int num_errors = 0, n_checks = 0;
  always #10 sys_clk = ~sys_clk;
  flash_driver_control_register #(.TIMEOUT_CYCLES(20)) i_dut (.sys_clk, .rst_n, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .parallelMode, .dualLed, .strobePin, .lampPin,
    .coilCurrentMa, .drive, .currentMa, .inductor_peak_limit, .coilFault);
  flash_host_model i_host (.sys_clk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  // Bounded wait for the flash drive to reach a level.
  task wt(input logic v, input int lim);
    for (int n = 0; drive.flashOn !== v; n++) begin
      if (n > lim) begin num_errors++; $display("[ERR] %0t timeout", $time); give_verdict(); end
      settle(1);
    end
  endtask : wt
  task t_regs;
    i_host.rd(8'h04, rv);
    `CHK(rv, 8'hB4)
    for (int i = 0; i < 4; i++) begin
      i_host.wr(8'h04, {i[1:0], 6'h00});
      i_host.rd(8'h04, rv);
      `CHK(inductor_peak_limit, i[1:0])
      `CHK(rv, {i[1:0], 6'h00})
    end
    i_host.rd(8'h07, rv);
    `CHK(rv, 8'h00)
  endtask : t_regs
  task t_mode;
    i_host.wr(8'h04, 8'h98);
    @(posedge sys_clk) lampPin <= 1'b1;
    settle(8);
    `CHK(drive, 4'h8)
    i_host.wr(8'h04, 8'h88);
    settle(8);
    `CHK(drive, 4'h0)
    i_host.wr(8'h04, 8'h89);
    settle(4);
    `CHK(drive, 4'h4)
    i_host.wr(8'h04, 8'h8A);
    settle(4);
    `CHK(drive, 4'h2)
    @(posedge sys_clk) lampPin <= 1'b0;
  endtask : t_mode
  task t_flash;
    i_host.wr(8'h04, 8'h8B);
    wt(1'b1, 4);
    settle(10);
    `CHK(drive.flashOn, 1'b1)
    wt(1'b0, 20);
    i_host.rd(8'h04, rv);
    `CHK(rv, 8'h83)
  endtask : t_flash
  task t_strobe;
    i_host.wr(8'h04, 8'h8F);
    settle(10);
    `CHK(drive.flashOn, 1'b0)
    @(posedge sys_clk) strobePin <= 1'b1;
    wt(1'b1, 8);
    wt(1'b0, 30);
    i_host.wr(8'h04, 8'h8F);
    settle(10);
    `CHK(drive.flashOn, 1'b0)
    i_host.wr(8'h04, 8'hAF);
    wt(1'b1, 8);
    @(posedge sys_clk) strobePin <= 1'b0;
    wt(1'b0, 8);
  endtask : t_strobe
  task t_par;
    @(posedge sys_clk) parallelMode <= 1'b1;
    strobePin <= 1'b1;
    wt(1'b1, 8);
    settle(2);
    `CHK(currentMa, 10'h1F4)
    @(posedge sys_clk) dualLed <= 1'b1;
    settle(3);
    `CHK(currentMa, 10'h140)
    @(posedge sys_clk) strobePin <= 1'b0;
    lampPin <= 1'b1;
    settle(8);
    `CHK(currentMa, 10'h028)
    @(posedge sys_clk) dualLed <= 1'b0;
    settle(3);
    `CHK(currentMa, 10'h050)
    @(posedge sys_clk) parallelMode <= 1'b0;
    lampPin <= 1'b0;
  endtask : t_par
  task t_fault;
    i_host.wr(8'h04, 8'h80);
    @(posedge sys_clk) coilCurrentMa <= 12'h6D6;
    settle(3);
    `CHK(coilFault, 1'b0)
    @(posedge sys_clk) coilCurrentMa <= 12'h6D7;
    settle(3);
    `CHK(coilFault, 1'b1)
    @(posedge sys_clk) coilCurrentMa <= 12'h000;
    i_host.rd(8'h05, rv);
    `CHK(rv, 8'h02)
    settle(2);
    `CHK(coilFault, 1'b0)
  endtask : t_fault
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_mode();
    t_flash();
    t_strobe();
    t_par();
    t_fault();
    give_verdict();
  end
endmodule : tb_top
bind flash_driver_control_register flash_ctrl_monitor i_mon (.sys_clk, .rst_n, .regRead,
  .regWrite, .regAddr, .regWdata, .regRdata, .parallelMode, .dualLed, .coilCurrentMa, .drive,
  .currentMa, .inductor_peak_limit, .coilFault);
`default_nettype wire
